//--- irq_agg_pkg.sv
package irq_agg_pkg;
  localparam int DATA_W = 32;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 10;
  localparam int NUM_AREAS = 4;
  localparam int LINK_RO_W = 16;
  localparam int LINK_CTL_W = 16;
  localparam int SUM_PAD_W = DATA_W - NUM_AREAS;
  localparam int WBUF_W = DATA_W - BYTE_W;
  localparam logic [1:0] FIRST_LANE = 2'h0;
  localparam logic [1:0] LAST_LANE = 2'h3;
  // Device register map (byte addresses)
  localparam logic [ADDR_W-1:0] OFF_IDENT = 10'h000;
  localparam logic [ADDR_W-1:0] OFF_LINK_CTL = 10'h004;
  localparam logic [ADDR_W-1:0] OFF_LINK_ST = 10'h008;
  localparam logic [ADDR_W-1:0] OFF_LINK_EN = 10'h00C;
  localparam logic [ADDR_W-1:0] OFF_GLOBAL = 10'h020;
  localparam logic [ADDR_W-1:0] OFF_TX_ST = 10'h030;
  localparam logic [ADDR_W-1:0] OFF_TX_EN = 10'h034;
  localparam logic [ADDR_W-1:0] OFF_RX_ST = 10'h038;
  localparam logic [ADDR_W-1:0] OFF_RX_EN = 10'h03C;
  localparam logic [ADDR_W-1:0] OFF_AS_ST = 10'h040;
  localparam logic [ADDR_W-1:0] OFF_AS_EN = 10'h044;
  // Area order equals summary bit order: link, tx, rx, async
  localparam logic [NUM_AREAS-1:0][ADDR_W-1:0] ST_OFFS = {OFF_AS_ST, OFF_RX_ST, OFF_TX_ST, OFF_LINK_ST};
  localparam logic [NUM_AREAS-1:0][ADDR_W-1:0] EN_OFFS = {OFF_AS_EN, OFF_RX_EN, OFF_TX_EN, OFF_LINK_EN};
  localparam logic [DATA_W-1:0] AREA_IMPL_MASK = 32'hFFFFFFFF;
  localparam logic [DATA_W-1:0] ENABLE_RESET = 32'h00000000;
  localparam logic [LINK_CTL_W-1:0] LINK_CTL_RESET = 16'h0000;
  // Host controller map (AXI4-Lite byte addresses)
  localparam int AXI_ADDR_W = 8;
  localparam logic [AXI_ADDR_W-1:0] H_OFF_ADDR = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] H_OFF_WDATA = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] H_OFF_CMD = 8'h08;
  localparam logic [AXI_ADDR_W-1:0] H_OFF_RDATA = 8'h0C;
  localparam logic [AXI_ADDR_W-1:0] H_OFF_STAT = 8'h10;
  localparam logic [AXI_ADDR_W-1:0] H_OFF_ISTAT = 8'h14;
  localparam logic [AXI_ADDR_W-1:0] H_OFF_IMASK = 8'h18;
  localparam int CMD_RD_BIT = 0;
  localparam int CMD_WR_BIT = 1;
  localparam int H_IRQ_W = 2;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_DEV_BIT = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- hif_if.sv
`timescale 1ns/1ps
`default_nettype none
// Byte-wide host interface between controller and device
interface hif_if;
  import irq_agg_pkg::*;
  logic req;
  logic wr;
  logic [ADDR_W-1:0] addr;
  logic [BYTE_W-1:0] wdata;
  logic ack;
  logic [BYTE_W-1:0] rdata;
  logic host_irq_n;
  modport dev (input req, input wr, input addr, input wdata, output ack, output rdata, output host_irq_n);
  modport host (output req, output wr, output addr, output wdata, input ack, input rdata, input host_irq_n);
endinterface
`default_nettype wire

//--- av_link_irq_dev.sv
`timescale 1ns/1ps
`default_nettype none
module av_link_irq_dev #(
  // Identity value is arbitrary
  parameter logic [irq_agg_pkg::DATA_W-1:0] IDENT_VALUE = 32'h00010001
) (
  input wire logic clk_i,
  input wire logic srst_i,
  hif_if.dev hif,
  input wire logic [irq_agg_pkg::NUM_AREAS-1:0][irq_agg_pkg::DATA_W-1:0] area_event_i,
  input wire logic [irq_agg_pkg::LINK_RO_W-1:0] link_state_i,
  output logic [irq_agg_pkg::LINK_CTL_W-1:0] link_ctrl_o,
  output logic [irq_agg_pkg::NUM_AREAS-1:0] area_pending_o
);
  import irq_agg_pkg::*;

  typedef struct packed {
    logic [LINK_CTL_W-1:0] link_ctl;
    logic [NUM_AREAS-1:0][DATA_W-1:0] status;
    logic [NUM_AREAS-1:0][DATA_W-1:0] enable;
    logic [WBUF_W-1:0] wbuf;
    logic [DATA_W-1:0] rbuf;
    logic ack;
    logic [BYTE_W-1:0] rdata;
  } dev_state_t;

  dev_state_t s_r;
  dev_state_t s_nxt;
  logic [NUM_AREAS-1:0] summary;
  logic [NUM_AREAS-1:0][DATA_W-1:0] clr;
  logic [DATA_W-1:0] rword;
  logic [DATA_W-1:0] wq;
  logic [ADDR_W-1:0] qaddr;
  logic [1:0] lane;
  logic access;
  logic [2:0] st_hit;
  logic [2:0] en_hit;

  // Match a quadlet address against one offset per area: {hit, index}
  function automatic logic [2:0] area_hit(input logic [ADDR_W-1:0] a,
                                          input logic [NUM_AREAS-1:0][ADDR_W-1:0] offs);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 0; i < NUM_AREAS; i++) begin
      if (a == offs[i]) begin
        r = {1'b1, i[1:0]};
      end
    end
    return r;
  endfunction

  // Area summaries: OR of enabled latched bits, never stored
  always_comb begin
    for (int i = 0; i < NUM_AREAS; i++) begin
      summary[i] = |(s_r.status[i] & s_r.enable[i]);
    end
  end

  // Single active-low line covering every area
  assign hif.host_irq_n = ~(|summary);
  assign hif.ack = s_r.ack;
  assign hif.rdata = s_r.rdata;
  assign link_ctrl_o = s_r.link_ctl;
  assign area_pending_o = summary;

  // Byte lane and quadlet address of the current access
  assign lane = hif.addr[1:0];
  assign qaddr = {hif.addr[ADDR_W-1:2], 2'b00};
  assign st_hit = area_hit(qaddr, ST_OFFS);
  assign en_hit = area_hit(qaddr, EN_OFFS);
  // One access per request; the ack cycle ignores req
  assign access = hif.req && !s_r.ack;
  assign wq = {hif.wdata, s_r.wbuf};

  // Read view of the addressed quadlet
  always_comb begin
    rword = '0;
    if (qaddr == OFF_IDENT) begin
      rword = IDENT_VALUE;
    end else if (qaddr == OFF_LINK_CTL) begin
      rword = {link_state_i, s_r.link_ctl};
    end else if (qaddr == OFF_GLOBAL) begin
      rword = {{SUM_PAD_W{1'b0}}, summary};
    end else if (st_hit[2]) begin
      rword = s_r.status[st_hit[1:0]];
    end else if (en_hit[2]) begin
      rword = s_r.enable[en_hit[1:0]];
    end
  end

  // Next state: register access, then event latching
  always_comb begin
    s_nxt = s_r;
    s_nxt.ack = 1'b0;
    clr = '0;
    if (access) begin
      s_nxt.ack = 1'b1;
      if (hif.wr) begin
        if (lane != LAST_LANE) begin
          // Bytes are staged so a register only ever sees a whole quadlet
          s_nxt.wbuf[BYTE_W*lane +: BYTE_W] = hif.wdata;
        end else if (qaddr == OFF_LINK_CTL) begin
          s_nxt.link_ctl = wq[LINK_CTL_W-1:0];
        end else if (st_hit[2]) begin
          clr[st_hit[1:0]] = wq;
        end else if (en_hit[2]) begin
          s_nxt.enable[en_hit[1:0]] = wq & AREA_IMPL_MASK;
        end
      end else begin
        // Lane zero snapshots the quadlet; later lanes read the snapshot
        if (lane == FIRST_LANE) begin
          s_nxt.rbuf = rword;
          s_nxt.rdata = rword[BYTE_W-1:0];
        end else begin
          s_nxt.rdata = s_r.rbuf[BYTE_W*lane +: BYTE_W];
        end
      end
    end
    // Set beats clear, so an event in the clear cycle is kept
    for (int i = 0; i < NUM_AREAS; i++) begin
      s_nxt.status[i] = (s_r.status[i] & ~clr[i]) | (area_event_i[i] & AREA_IMPL_MASK);
    end
  end

  // State register with synchronous reset to defaults
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_r.link_ctl <= LINK_CTL_RESET;
      s_r.status <= '0;
      s_r.enable <= {NUM_AREAS{ENABLE_RESET}};
      s_r.wbuf <= '0;
      s_r.rbuf <= '0;
      s_r.ack <= 1'b0;
      s_r.rdata <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule
`default_nettype wire

//--- av_link_host_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module av_link_host_ctrl (
  input wire logic clk_i,
  input wire logic srst_i,
  hif_if.host hif,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [irq_agg_pkg::AXI_ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [irq_agg_pkg::DATA_W-1:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [irq_agg_pkg::AXI_ADDR_W-1:0] s_axi_araddr_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [irq_agg_pkg::DATA_W-1:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic irq_o
);
  import irq_agg_pkg::*;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_XFER = 1'b1
  } link_fsm_t;

  typedef struct packed {
    link_fsm_t fsm;
    logic aw_ok;
    logic [AXI_ADDR_W-1:0] aw_addr;
    logic w_ok;
    logic [DATA_W-1:0] w_data;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [DATA_W-1:0] rdata;
    logic [ADDR_W-1:0] tgt_addr;
    logic [DATA_W-1:0] tgt_wdata;
    logic [DATA_W-1:0] tgt_rdata;
    logic [1:0] lane;
    logic is_wr;
    logic irq_n_prev;
    logic [H_IRQ_W-1:0] istat;
    logic [H_IRQ_W-1:0] imask;
  } host_state_t;

  host_state_t s_r;
  host_state_t s_nxt;
  logic [H_IRQ_W-1:0] set_ev;
  logic [H_IRQ_W-1:0] clr_ev;
  logic busy;

  assign busy = (s_r.fsm == ST_XFER);
  // Handshake readies from state; one write and one read in flight
  assign s_axi_awready_o = !s_r.aw_ok && !s_r.bvalid;
  assign s_axi_wready_o = !s_r.w_ok && !s_r.bvalid;
  assign s_axi_arready_o = !s_r.rvalid;
  assign s_axi_bvalid_o = s_r.bvalid;
  assign s_axi_bresp_o = s_r.bresp;
  assign s_axi_rvalid_o = s_r.rvalid;
  assign s_axi_rresp_o = s_r.rresp;
  assign s_axi_rdata_o = s_r.rdata;
  assign irq_o = |(s_r.istat & s_r.imask);
  // Link outputs straight from state; every transfer is four lanes
  assign hif.req = busy;
  assign hif.wr = s_r.is_wr;
  assign hif.addr = {s_r.tgt_addr[ADDR_W-1:2], s_r.lane};
  assign hif.wdata = s_r.tgt_wdata[BYTE_W*s_r.lane +: BYTE_W];

  always_comb begin
    s_nxt = s_r;
    set_ev = '0;
    clr_ev = '0;
    s_nxt.irq_n_prev = hif.host_irq_n;
    // New assertion of the device line is an event
    set_ev[IRQ_DEV_BIT] = s_r.irq_n_prev && !hif.host_irq_n;
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      s_nxt.aw_ok = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      s_nxt.w_ok = 1'b1;
      s_nxt.w_data = s_axi_wdata_i;
    end
    if (s_r.bvalid && s_axi_bready_i) begin
      s_nxt.bvalid = 1'b0;
    end
    // Register write once both address and data are held
    if (s_r.aw_ok && s_r.w_ok) begin
      s_nxt.aw_ok = 1'b0;
      s_nxt.w_ok = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = RESP_OKAY;
      unique case (s_r.aw_addr)
        H_OFF_ADDR: s_nxt.tgt_addr = s_r.w_data[ADDR_W-1:0];
        H_OFF_WDATA: s_nxt.tgt_wdata = s_r.w_data;
        H_OFF_CMD: begin
          // A command while busy is dropped; software polls the busy bit
          if (!busy && (s_r.w_data[CMD_WR_BIT] || s_r.w_data[CMD_RD_BIT])) begin
            s_nxt.fsm = ST_XFER;
            s_nxt.lane = FIRST_LANE;
            s_nxt.is_wr = s_r.w_data[CMD_WR_BIT];
          end
        end
        H_OFF_ISTAT: clr_ev = s_r.w_data[H_IRQ_W-1:0];
        H_OFF_IMASK: s_nxt.imask = s_r.w_data[H_IRQ_W-1:0];
        H_OFF_RDATA, H_OFF_STAT: ;
        default: s_nxt.bresp = RESP_SLVERR;
      endcase
    end
    if (s_r.rvalid && s_axi_rready_i) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = RESP_OKAY;
      s_nxt.rdata = '0;
      unique case (s_axi_araddr_i)
        H_OFF_ADDR: s_nxt.rdata = {{(DATA_W-ADDR_W){1'b0}}, s_r.tgt_addr};
        H_OFF_WDATA: s_nxt.rdata = s_r.tgt_wdata;
        H_OFF_CMD: ;
        H_OFF_RDATA: s_nxt.rdata = s_r.tgt_rdata;
        H_OFF_STAT: s_nxt.rdata = {{(DATA_W-2){1'b0}}, !hif.host_irq_n, busy};
        H_OFF_ISTAT: s_nxt.rdata = {{(DATA_W-H_IRQ_W){1'b0}}, s_r.istat};
        H_OFF_IMASK: s_nxt.rdata = {{(DATA_W-H_IRQ_W){1'b0}}, s_r.imask};
        default: s_nxt.rresp = RESP_SLVERR;
      endcase
    end
    // Byte lanes in order 0..3; req held high, device acks each lane
    if (busy && hif.ack) begin
      if (!s_r.is_wr) begin
        s_nxt.tgt_rdata[BYTE_W*s_r.lane +: BYTE_W] = hif.rdata;
      end
      s_nxt.lane = s_r.lane + 2'h1;
      if (s_r.lane == LAST_LANE) begin
        s_nxt.fsm = ST_IDLE;
        set_ev[IRQ_DONE_BIT] = 1'b1;
      end
    end
    // Set beats clear for the sticky bits
    s_nxt.istat = (s_r.istat & ~clr_ev) | set_ev;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_r <= '0;
      s_r.fsm <= ST_IDLE;
      s_r.irq_n_prev <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule
`default_nettype wire

//--- hif_irq_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module hif_irq_asserts (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic req,
  input wire logic wr,
  input wire logic [irq_agg_pkg::ADDR_W-1:0] addr,
  input wire logic [irq_agg_pkg::BYTE_W-1:0] wdata,
  input wire logic ack,
  input wire logic [irq_agg_pkg::BYTE_W-1:0] rdata,
  input wire logic host_irq_n
);
  import irq_agg_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // Lane handshake: taken while ack low, then one ack cycle
  sequence s_taken;
    req && !ack;
  endsequence
  sequence s_answer;
    ack ##1 !ack;
  endsequence
  a_ack_one_pulse: assert property (s_taken |=> s_answer) else $error("lane not acked once");
  a_ack_needs_req: assert property (!req |=> !ack) else $error("ack without request");
  a_lane_held: assert property (s_taken |=> req && $stable(wr) && $stable(addr) && $stable(wdata))
    else $error("lane changed before ack");
  a_lane_step: assert property (ack && addr[1:0] != LAST_LANE |=> req && wr == $past(wr) &&
    addr[1:0] == $past(addr[1:0]) + 2'h1) else $error("quadlet lanes out of order");
  a_quad_start: assert property ($rose(req) |-> addr[1:0] == FIRST_LANE) else $error("quadlet not at lane 0");
  a_rdata_hold: assert property (!(req && !wr && !ack) |=> $stable(rdata)) else $error("read data moved");
  // Line only released by a committed quadlet write
  a_irq_release: assert property ($rose(host_irq_n) |-> ack && wr && addr[1:0] == LAST_LANE)
    else $error("interrupt released without write");
  a_read_keeps_irq: assert property (req && !wr && !host_irq_n |=> !host_irq_n)
    else $error("read cleared interrupt");
endmodule
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import irq_agg_pkg::*;
  // Identity value is arbitrary
  localparam logic [DATA_W-1:0] ID_V = 32'h0000A5A5;
  logic clk_i = 0;
  logic srst_i = 1;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [AXI_ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [DATA_W-1:0] wdat = '0, rdat;
  logic [1:0] bresp, rresp;
  logic [NUM_AREAS-1:0][DATA_W-1:0] ev = '0;
  logic [LINK_RO_W-1:0] lstate = '0;
  logic [LINK_CTL_W-1:0] lctl;
  logic [NUM_AREAS-1:0] pend;
  int errors = 0;
  int comparisons = 0;
  hif_if bus ();
  always #10 clk_i = ~clk_i;
  av_link_irq_dev #(.IDENT_VALUE(ID_V)) i_av_link_irq_dev (.clk_i(clk_i), .srst_i(srst_i), .hif(bus.dev),
    .area_event_i(ev), .link_state_i(lstate), .link_ctrl_o(lctl), .area_pending_o(pend));
  av_link_host_ctrl i_av_link_host_ctrl (.clk_i(clk_i), .srst_i(srst_i), .hif(bus.host),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_wdata_i(wdat), .s_axi_wstrb_i(4'hF), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .s_axi_rdata_o(rdat),
    .s_axi_rresp_o(rresp), .irq_o(irq));
  hif_irq_asserts i_hif_irq_asserts (.clk_i(clk_i), .srst_i(srst_i), .req(bus.req), .wr(bus.wr),
    .addr(bus.addr), .wdata(bus.wdata), .ack(bus.ack), .rdata(bus.rdata), .host_irq_n(bus.host_irq_n));
  // Compare helpers, one per result kind
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: word %h, wanted %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: bit %b, wanted %b", $time, g, e);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Expected summary word for one area
  function automatic logic [31:0] glob(input int a, input logic [31:0] s, input logic [31:0] m);
    glob = 32'h0;
    glob[a] = |(s & m);
  endfunction
  // Ready sampled mid-cycle; it is stable up to the next edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw, ta, tw;
    pa = 1;
    pw = 1;
    @(posedge clk_i);
    awvalid <= 1;
    awaddr <= a;
    wvalid <= 1;
    wdat <= d;
    bready <= 1;
    while (pa || pw) begin
      @(negedge clk_i);
      ta = pa && awready;
      tw = pw && wready;
      @(posedge clk_i);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
    do @(negedge clk_i); while (!bvalid);
    @(posedge clk_i);
    bready <= 0;
    @(negedge clk_i);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    arvalid <= 1;
    araddr <= a;
    rready <= 1;
    do @(negedge clk_i); while (!arready);
    @(posedge clk_i);
    arvalid <= 0;
    do @(negedge clk_i); while (!rvalid);
    d = rdat;
    r = rresp;
    @(posedge clk_i);
    rready <= 0;
    @(negedge clk_i);
  endtask
  // Device access through the controller, polling busy
  task automatic wait_idle();
    logic [31:0] s;
    logic [1:0] r;
    do axi_rd(H_OFF_STAT, s, r); while (s[0] !== 1'b0);
  endtask
  task automatic dev_wr(input logic [9:0] a, input logic [31:0] d);
    axi_wr(H_OFF_ADDR, {22'h0, a});
    axi_wr(H_OFF_WDATA, d);
    axi_wr(H_OFF_CMD, 32'h2);
    wait_idle();
  endtask
  task automatic dev_rd(input logic [9:0] a, output logic [31:0] d);
    logic [1:0] r;
    axi_wr(H_OFF_ADDR, {22'h0, a});
    axi_wr(H_OFF_CMD, 32'h1);
    wait_idle();
    axi_rd(H_OFF_RDATA, d, r);
  endtask
  // Watchdog, far beyond the expected run
  initial begin
    repeat (40000) @(posedge clk_i);
    errors++;
    summarize();
  end
  initial begin
    logic [31:0] d, n, e, t;
    logic [1:0] r;
    void'($urandom(32'h5c21));
    lstate = $urandom;
    repeat (2) @(posedge clk_i);
    srst_i <= 0;
    @(negedge clk_i);
    chk1(bus.host_irq_n, 1'b1);
    dev_rd(OFF_IDENT, d);
    chk32(d, ID_V);
    dev_wr(OFF_IDENT, ~ID_V);
    dev_rd(OFF_IDENT, d);
    chk32(d, ID_V);
    dev_rd(OFF_LINK_CTL, d);
    chk32(d, {lstate, LINK_CTL_RESET});
    n = $urandom;
    dev_wr(OFF_LINK_CTL, n);
    dev_rd(OFF_LINK_CTL, d);
    chk32(d, {lstate, n[15:0]});
    chk32({16'h0, lctl}, {16'h0, n[15:0]});
    axi_rd(8'hFC, d, r);
    chk32({30'h0, r}, {30'h0, RESP_SLVERR});
    axi_wr(H_OFF_IMASK, 32'h2);
    $display("test reset and access done");
    // Each area: latch unenabled, enable, summary, acknowledge
    for (int a = 0; a < NUM_AREAS; a++) begin
      n = (a == 3) ? 32'h80000000 : ($urandom | 32'h1);
      e = $urandom | (n & -n);
      @(posedge clk_i);
      ev[a] <= n;
      @(posedge clk_i);
      ev[a] <= '0;
      dev_rd(ST_OFFS[a], d);
      chk32(d, n);
      dev_rd(OFF_GLOBAL, d);
      chk32(d, 32'h0);
      dev_wr(EN_OFFS[a], e);
      dev_rd(OFF_GLOBAL, d);
      chk32(d, glob(a, n, e));
      chk1(pend[a], 1'b1);
      chk1(bus.host_irq_n, 1'b0);
      chk1(irq, 1'b1);
      // Controller status bit 1 reads 1 while the device line is low
      axi_rd(H_OFF_STAT, t, r);
      chk1(t[1], 1'b1);
      chk32({30'h0, r}, {30'h0, RESP_OKAY});
      dev_wr(OFF_GLOBAL, ~d);
      dev_rd(OFF_GLOBAL, d);
      chk32(d, glob(a, n, e));
      dev_wr(ST_OFFS[a], 32'h0);
      dev_rd(ST_OFFS[a], d);
      chk32(d, n);
      dev_wr(ST_OFFS[a], n);
      dev_rd(ST_OFFS[a], d);
      chk32(d, 32'h0);
      dev_rd(OFF_GLOBAL, d);
      chk32(d, 32'h0);
      chk1(bus.host_irq_n, 1'b1);
      axi_wr(H_OFF_ISTAT, 32'h3);
      chk1(irq, 1'b0);
      $display("test area %0d done", a);
    end
    // Reset in mid-run with an event pending
    @(posedge clk_i);
    ev[1] <= 32'h00010000;
    @(posedge clk_i);
    ev[1] <= '0;
    srst_i <= 1;
    repeat (2) @(posedge clk_i);
    srst_i <= 0;
    @(negedge clk_i);
    chk1(bus.host_irq_n, 1'b1);
    dev_rd(OFF_TX_ST, d);
    chk32(d, 32'h0);
    dev_rd(OFF_TX_EN, d);
    chk32(d, ENABLE_RESET);
    $display("test second reset done");
    summarize();
  end
endmodule
`default_nettype wire
